// [common/hts_pkg.sv]
// Shared constants and types of the sensor command unit: bus address, command codes,
// config/status register layout, conversion times and the conversion request carrier.
// Assumes a 100 MHz system clock; times are kept in ms and scaled in the top module.
package hts_pkg;
   // Bus header and command codes
   localparam logic [6:0] DEV_ADDR = 7'h40;
   localparam logic [7:0] CMD_T_HOLD = 8'hE3;
   localparam logic [7:0] CMD_H_HOLD = 8'hE5;
   localparam logic [7:0] CMD_T_POLL = 8'hF3;
   localparam logic [7:0] CMD_H_POLL = 8'hF5;
   localparam logic [7:0] CMD_WR_REG = 8'hE6;
   localparam logic [7:0] CMD_RD_REG = 8'hE7;
   localparam logic [7:0] CMD_SOFT_RST = 8'hFE;
   // Config/status register field positions and values after reset
   localparam int RES_HI_BIT = 7;
   localparam int LOW_SUP_BIT = 6;
   localparam int HEATER_BIT = 2;
   localparam int NO_RELOAD_BIT = 1;
   localparam int RES_LO_BIT = 0;
   localparam logic [1:0] RES_RESET = 2'h0;
   localparam logic HEATER_RESET = 1'b0;
   localparam logic NO_RELOAD_RESET = 1'b1;
   localparam logic LOW_SUP_RESET = 1'b0;
   // Checksum generator x^8+x^5+x^4+1 and start value
   localparam logic [7:0] CRC_POLY = 8'h31;
   localparam logic [7:0] CRC_INIT = 8'h00;
   // Longest conversion times in ms, by resolution
   localparam int unsigned T_MS_14 = 85;
   localparam int unsigned T_MS_13 = 43;
   localparam int unsigned T_MS_12 = 22;
   localparam int unsigned T_MS_11 = 11;
   localparam int unsigned H_MS_12 = 29;
   localparam int unsigned H_MS_11 = 15;
   localparam int unsigned H_MS_10 = 9;
   localparam int unsigned H_MS_8 = 4;
   localparam int unsigned BOOT_MS = 15;
   // Clock rate and derived cycles per ms
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned MS_CYCLES = CLK_HZ / 1000;
   localparam int unsigned FIFO_DEPTH = 8;
   localparam int unsigned SAMPLE_W = 16;

   typedef enum {ST_BOOT, ST_IDLE, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK, ST_STRETCH} hts_state_t;
   typedef enum {RX_HDR, RX_CMD, RX_WDATA} hts_rx_t;
   typedef enum {FOL_RX, FOL_TXREG, FOL_TXRES, FOL_STRETCH, FOL_NONE, FOL_RESET} hts_follow_t;

   // Request handed to the analog front end with each conversion start
   typedef struct packed {
      logic humidity;
      logic [1:0] resolution;
   } hts_conv_t;
endpackage : hts_pkg

// [design/hts_unit.sv]
// Command unit of a humidity/temperature sensor acting as a bus slave on SCL/SDA,
// plus the sample FIFO between the analog front end and the unit.
// Assumes open-drain pads outside (oe high pulls the wire low) and a front end that
// starts a conversion on conv_start and pushes one 16-bit sample into the FIFO.
//
// Contract
// - Header is fixed 7-bit address plus direction
// - Acknowledge each good byte after eighth fall
// - E3/E5 start clock-stretching temperature/humidity conversions
// - F3/F5 start polled conversions, SCL free
// - E6 writes register, E7 reads it back
// - Hold SCL low until conversion completes
// - Acknowledge polled read header only when done
// - Unfinished polled conversion leaves header unacknowledged
// - Result bit one marks humidity, bit zero zero
// - Master NACK skips checksum, else send it
// - Temperature conversion bounded 85/43/22/11 ms
// - Humidity conversion bounded 29/15/9/4 ms
// - Repeated Start accepted in place of Stop
// - Command FE performs a soft reset
// - Soft reset keeps heater, under 15 ms
// - Bits seven and zero select resolution
// - Bit six low-supply flag, refreshed per measurement
// - Bit two switches the heater on
// - Bit one cleared reloads defaults per measurement
// - Checksum is CRC-8 polynomial 0x31
// - Results two bytes, MSB first, each acknowledged
// - Idle after 15 ms of SCL high
`timescale 1ns/100ps
`default_nettype none

// Sample buffer: flip-flop storage, pointers one bit wider than the index
module hts_fifo #(
   parameter int unsigned WIDTH = 16,
   parameter int unsigned DEPTH = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;

   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_check
      $error("hts_fifo depth must be a power of two of at least 2");
   end

   // Full when pointers differ only in the wrap bit
   assign in_ready = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
   assign out_valid = wr_ptr != rd_ptr;
   assign out_data = mem[rd_ptr[AW-1:0]];

   // Pointer update
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (in_valid && in_ready) wr_ptr <= wr_ptr + 1'b1;
         if (out_valid && out_ready) rd_ptr <= rd_ptr + 1'b1;
      end
   end

   // Storage write, no reset needed on data
   always_ff @(posedge clk) begin
      if (in_valid && in_ready) mem[wr_ptr[AW-1:0]] <= in_data;
   end
endmodule : hts_fifo

module hts_unit #(
   parameter int unsigned CYCLES_PER_MS = hts_pkg::MS_CYCLES,
   parameter logic [2:0] RSVD_VALUE = 3'h0  // Reserved field read value, arbitrary
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Bus pins, open drain
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Analog front end
   output logic conv_start,
   output hts_pkg::hts_conv_t conv_req,
   output logic heater_on,
   input wire logic low_supply_in,
   input wire logic sample_valid,
   output logic sample_ready,
   input wire logic [hts_pkg::SAMPLE_W-1:0] sample_data
);
   import hts_pkg::*;

   if (CYCLES_PER_MS < 1 || CYCLES_PER_MS > 40_000_000) begin : g_param_check
      $error("hts_unit CYCLES_PER_MS out of range");
   end

   localparam logic [31:0] BOOT_CYC = 32'(BOOT_MS * CYCLES_PER_MS - 2);  // Two short so boot ends inside the limit
   localparam logic [31:0] H_MAX_CYC = 32'(H_MS_12 * CYCLES_PER_MS);
   localparam logic [31:0] T_MAX_CYC = 32'(T_MS_14 * CYCLES_PER_MS);

   hts_state_t state;
   hts_rx_t rx_kind;
   hts_follow_t follow;
   logic [2:0] scl_sync, sda_sync, sup_sync;
   logic scl_f, sda_f, scl_prev, sda_prev, low_sup_f;
   logic scl_rise, scl_fall, start_det, stop_det;
   logic [3:0] bitcnt;
   logic [7:0] shreg;
   logic sda_drive, scl_hold, pending_reg_read, master_ack;
   logic [23:0] tx_buf;
   logic [1:0] tx_left;
   logic [31:0] boot_timer, timer;
   logic busy, busy_hold, conv_hum, result_ready;
   logic [15:0] result;
   logic [1:0] res;
   logic heater, no_reload, low_sup;
   logic [7:0] ureg_val;
   logic byte_end, addr_hit, hdr_write, hdr_read, cmd_byte, wdata_byte;
   logic is_meas, cmd_ok, launch, load_result, soft_go;
   logic fifo_valid;
   logic [SAMPLE_W-1:0] fifo_data;
   hts_follow_t read_follow;

   // One checksum step over a byte, MSB first
   function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic [7:0] data);
      logic [7:0] c;
      c = crc ^ data;
      for (int i = 0; i < 8; i++) begin
         c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
      end
      return c;
   endfunction : crc_step

   // Longest conversion time for a resolution code and kind
   function automatic logic [31:0] conv_limit(input logic [1:0] r, input logic hum);
      int unsigned ms;
      ms = 0;
      case ({hum, r})
         3'b000: ms = T_MS_14;
         3'b001: ms = T_MS_12;
         3'b010: ms = T_MS_13;
         3'b011: ms = T_MS_11;
         3'b100: ms = H_MS_12;
         3'b101: ms = H_MS_8;
         3'b110: ms = H_MS_10;
         default: ms = H_MS_11;
      endcase
      return 32'(ms * CYCLES_PER_MS);
   endfunction : conv_limit

   // Pin synchronisers; a level counts once stages two and three agree
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         scl_sync <= 3'h7;
         sda_sync <= 3'h7;
         sup_sync <= 3'h0;
         scl_f <= 1'b1;
         sda_f <= 1'b1;
         low_sup_f <= 1'b0;
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
      end else begin
         scl_sync <= {scl_sync[1:0], scl_in};
         sda_sync <= {sda_sync[1:0], sda_in};
         sup_sync <= {sup_sync[1:0], low_supply_in};
         if (scl_sync[1] == scl_sync[2]) scl_f <= scl_sync[2];
         if (sda_sync[1] == sda_sync[2]) sda_f <= sda_sync[2];
         if (sup_sync[1] == sup_sync[2]) low_sup_f <= sup_sync[2];
         scl_prev <= scl_f;
         sda_prev <= sda_f;
      end
   end

   // Bus events; a Start may come instead of a Stop at any point
   assign scl_rise = scl_f && !scl_prev;
   assign scl_fall = !scl_f && scl_prev;
   assign start_det = scl_f && scl_prev && sda_prev && !sda_f;
   assign stop_det = scl_f && scl_prev && !sda_prev && sda_f;

   // Byte decode, valid in the cycle that the eighth bit ends
   assign byte_end = (state == ST_RX) && scl_fall && (bitcnt == 4'h8);
   assign addr_hit = shreg[7:1] == DEV_ADDR;
   assign hdr_write = byte_end && (rx_kind == RX_HDR) && addr_hit && !shreg[0];
   assign hdr_read = byte_end && (rx_kind == RX_HDR) && addr_hit && shreg[0];
   assign cmd_byte = byte_end && (rx_kind == RX_CMD);
   assign wdata_byte = byte_end && (rx_kind == RX_WDATA);
   assign is_meas = (shreg == CMD_T_HOLD) || (shreg == CMD_H_HOLD) ||
                    (shreg == CMD_T_POLL) || (shreg == CMD_H_POLL);
   assign cmd_ok = is_meas || (shreg == CMD_WR_REG) || (shreg == CMD_RD_REG) ||
                   (shreg == CMD_SOFT_RST);
   assign launch = cmd_byte && is_meas;
   assign load_result = (state == ST_RX_ACK && scl_fall && follow == FOL_TXRES) ||
                        (state == ST_STRETCH && result_ready);
   assign soft_go = (state == ST_RX_ACK) && scl_fall && (follow == FOL_RESET);

   // A read header is answered only when something is there to send or a hold conversion is running
   always_comb begin
      if (pending_reg_read) read_follow = FOL_TXREG;
      else if (result_ready) read_follow = FOL_TXRES;
      else if (busy && busy_hold) read_follow = FOL_STRETCH;
      else read_follow = FOL_NONE;
   end

   // Register image: resolution split over bits seven and zero
   assign ureg_val = {res[1], low_sup, RSVD_VALUE, heater, no_reload, res[0]};

   // Bus slave state machine, owns both pin drivers
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= ST_BOOT;
         rx_kind <= RX_HDR;
         follow <= FOL_NONE;
         bitcnt <= 4'h0;
         shreg <= 8'h00;
         sda_drive <= 1'b0;
         scl_hold <= 1'b0;
         pending_reg_read <= 1'b0;
         master_ack <= 1'b0;
         tx_buf <= 24'h000000;
         tx_left <= 2'h0;
         boot_timer <= BOOT_CYC;
      end else if (state == ST_BOOT) begin
         // Only time spent with SCL high counts toward readiness
         if (boot_timer == 32'h0) state <= ST_IDLE;
         else if (scl_f) boot_timer <= boot_timer - 32'h1;
      end else if (start_det && !scl_hold) begin
         state <= ST_RX;
         rx_kind <= RX_HDR;
         bitcnt <= 4'h0;
         sda_drive <= 1'b0;
      end else if (stop_det && !scl_hold) begin
         state <= ST_IDLE;
         sda_drive <= 1'b0;
      end else begin
         case (state)
            ST_RX: begin
               if (scl_rise && bitcnt != 4'h8) begin
                  shreg <= {shreg[6:0], sda_f};
                  bitcnt <= bitcnt + 4'h1;
               end else if (byte_end) begin
                  state <= ST_RX_ACK;
                  if (rx_kind == RX_HDR) begin
                     follow <= !addr_hit ? FOL_NONE : (shreg[0] ? read_follow : FOL_RX);
                     sda_drive <= addr_hit && (!shreg[0] || read_follow != FOL_NONE);
                     rx_kind <= RX_CMD;
                  end else if (rx_kind == RX_CMD) begin
                     sda_drive <= cmd_ok;
                     follow <= !cmd_ok ? FOL_NONE : (shreg == CMD_SOFT_RST) ? FOL_RESET : FOL_RX;
                     rx_kind <= (shreg == CMD_WR_REG) ? RX_WDATA : RX_CMD;
                     if (shreg == CMD_RD_REG) pending_reg_read <= 1'b1;
                     else if (cmd_ok) pending_reg_read <= 1'b0;
                  end else begin
                     sda_drive <= 1'b1;
                     follow <= FOL_NONE;
                  end
               end
            end
            ST_RX_ACK: begin
               if (scl_fall) begin
                  sda_drive <= 1'b0;
                  bitcnt <= 4'h0;
                  case (follow)
                     FOL_RX: state <= ST_RX;
                     FOL_TXREG: begin
                        state <= ST_TX;
                        tx_buf <= {ureg_val, crc_step(CRC_INIT, ureg_val), 8'h00};
                        tx_left <= 2'h1;
                        sda_drive <= !ureg_val[7];
                        pending_reg_read <= 1'b0;
                     end
                     FOL_TXRES: begin
                        state <= ST_TX;
                        tx_buf <= {result, crc_step(crc_step(CRC_INIT, result[15:8]), result[7:0])};
                        tx_left <= 2'h2;
                        sda_drive <= !result[15];
                     end
                     FOL_STRETCH: begin
                        state <= ST_STRETCH;
                        scl_hold <= 1'b1;
                     end
                     FOL_RESET: begin
                        state <= ST_BOOT;
                        boot_timer <= BOOT_CYC;
                        pending_reg_read <= 1'b0;
                     end
                     default: state <= ST_IDLE;
                  endcase
               end
            end
            ST_STRETCH: begin
               // Clock stays held until the conversion has delivered
               if (result_ready) begin
                  scl_hold <= 1'b0;
                  state <= ST_TX;
                  bitcnt <= 4'h0;
                  tx_buf <= {result, crc_step(crc_step(CRC_INIT, result[15:8]), result[7:0])};
                  tx_left <= 2'h2;
                  sda_drive <= !result[15];
               end
            end
            ST_TX: begin
               // Bits change only after SCL falls, MSB first
               if (scl_fall) begin
                  if (bitcnt == 4'h7) begin
                     state <= ST_TX_ACK;
                     sda_drive <= 1'b0;
                  end else begin
                     tx_buf <= tx_buf << 1;
                     sda_drive <= !tx_buf[22];
                     bitcnt <= bitcnt + 4'h1;
                  end
               end
            end
            ST_TX_ACK: begin
               if (scl_rise) master_ack <= !sda_f;
               else if (scl_fall) begin
                  // A not-acknowledge ends the transfer, checksum or not
                  if (master_ack && tx_left != 2'h0) begin
                     state <= ST_TX;
                     tx_buf <= tx_buf << 1;
                     sda_drive <= !tx_buf[22];
                     tx_left <= tx_left - 2'h1;
                     bitcnt <= 4'h0;
                  end else begin
                     state <= ST_IDLE;
                  end
               end
            end
            default: ;
         endcase
      end
   end

   // Conversion control; the timer guarantees the longest time even without a sample
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         busy <= 1'b0;
         busy_hold <= 1'b0;
         conv_hum <= 1'b0;
         result_ready <= 1'b0;
         result <= 16'h0000;
         timer <= 32'h0;
         conv_start <= 1'b0;
         conv_req <= '0;
      end else begin
         conv_start <= 1'b0;
         if (load_result) result_ready <= 1'b0;
         if (soft_go) begin
            busy <= 1'b0;
            result_ready <= 1'b0;
         end else if (launch) begin
            // Reload mode measures with default resolution
            busy <= 1'b1;
            busy_hold <= !shreg[4];
            conv_hum <= shreg[2];
            result_ready <= 1'b0;
            conv_start <= 1'b1;
            conv_req <= '{humidity: shreg[2], resolution: no_reload ? res : RES_RESET};
            timer <= conv_limit(no_reload ? res : RES_RESET, shreg[2]) - 32'h1;
         end else if (busy) begin
            if (fifo_valid || timer == 32'h0) begin
               busy <= 1'b0;
               result_ready <= 1'b1;
               if (fifo_valid) result <= {fifo_data[15:2], conv_hum, 1'b0};
               else result <= {result[15:2], conv_hum, 1'b0};
            end else begin
               timer <= timer - 32'h1;
            end
         end
      end
   end

   // Config/status register; reserved bits are never stored
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         res <= RES_RESET;
         heater <= HEATER_RESET;
         no_reload <= NO_RELOAD_RESET;
         low_sup <= LOW_SUP_RESET;
      end else begin
         if (wdata_byte) begin
            res <= {shreg[RES_HI_BIT], shreg[RES_LO_BIT]};
            heater <= shreg[HEATER_BIT];
            no_reload <= shreg[NO_RELOAD_BIT];
         end
         if (soft_go || (launch && !no_reload)) begin
            res <= RES_RESET;
            no_reload <= NO_RELOAD_RESET;
            low_sup <= soft_go ? LOW_SUP_RESET : low_sup;
         end
         if (busy && (fifo_valid || timer == 32'h0)) low_sup <= low_sup_f;
      end
   end

   hts_fifo #(.WIDTH(SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .reset_n(reset_n),
      .in_valid(sample_valid),
      .in_ready(sample_ready),
      .in_data(sample_data),
      .out_valid(fifo_valid),
      .out_ready(busy),
      .out_data(fifo_data)
   );

   // Open-drain pins only ever pull low
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign scl_oe = scl_hold;
   assign sda_oe = sda_drive;
   assign heater_on = heater;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   addr_ack_a: assert property (hdr_write |=> sda_drive && state == ST_RX_ACK)
      else $error("own write header not acknowledged");
   foreign_addr_a: assert property (byte_end && rx_kind == RX_HDR && !addr_hit |=> !sda_drive [*2])
      else $error("foreign address acknowledged");
   stretch_hold_a: assert property (state == ST_STRETCH && !result_ready |=> scl_oe)
      else $error("clock not held during conversion");
   poll_nack_a: assert property (hdr_read && busy && !busy_hold && !pending_reg_read |=> !sda_oe)
      else $error("busy polled header acknowledged");
   status_bits_a: assert property ($rose(result_ready) |-> result[1:0] == {conv_hum, 1'b0})
      else $error("result status bits wrong");
   temp_bound_a: assert property (busy |-> timer < T_MAX_CYC)
      else $error("temperature conversion over limit");
   hum_bound_a: assert property (busy && conv_hum |-> timer < H_MAX_CYC)
      else $error("humidity conversion over limit");
   unknown_cmd_a: assert property (cmd_byte && !cmd_ok |=> !sda_oe && $stable({res, heater, no_reload}))
      else $error("unknown command had an effect");
   soft_reset_a: assert property (soft_go |=> state == ST_BOOT && res == RES_RESET && heater == $past(heater))
      else $error("soft reset restored wrong settings");
   otp_reload_a: assert property (launch && !no_reload |=> res == RES_RESET && no_reload ##1 conv_start == 1'b0)
      else $error("defaults not reloaded before measurement");

   hold_read_c: cover property (state == ST_STRETCH ##[1:1000] state == ST_TX);
   poll_retry_c: cover property (hdr_read && read_follow == FOL_NONE);
   soft_reset_c: cover property (soft_go);
   reg_read_c: cover property (state == ST_RX_ACK && scl_fall && follow == FOL_TXREG);
endmodule : hts_unit

`default_nettype wire

// [verif/hts_master.sv]
// Bus master model: moves SCL/SDA only by pulling them low, 170 ns bit time.
// Assumes the bench builds the wired-AND wires and calls the tasks in order.
`timescale 1ns/100ps
`default_nettype none
module hts_master (
   // Clock and wire levels
   input wire logic clk,
   input wire logic scl,
   input wire logic sda,
   // Pull-downs and stuck-clock flag
   output logic scl_pull,
   output logic sda_pull,
   output logic hang
);
   // Both lines released at power-up
   initial begin
      scl_pull = 1'b0;
      sda_pull = 1'b0;
      hang = 1'b0;
   end
   // A quarter bit is four system clocks
   task automatic q4(input int n);
      repeat (n * 4) @(posedge clk);
   endtask : q4
   // Release SCL; a device stretch is waited out, but never forever
   task automatic rise();
      int k;
      scl_pull <= 1'b0;
      for (k = 0; k < 3000 && !scl; k++) @(posedge clk);
      if (!scl) hang <= 1'b1;
   endtask : rise
   // Start, or repeated Start when the clock is low
   task automatic start();
      sda_pull <= 1'b0;
      q4(1);
      rise();
      q4(2);
      sda_pull <= 1'b1;
      q4(2);
      scl_pull <= 1'b1;
      q4(1);
   endtask : start
   // Stop, leaving both lines high
   task automatic stop();
      sda_pull <= 1'b1;
      q4(1);
      rise();
      q4(2);
      sda_pull <= 1'b0;
      q4(2);
   endtask : stop
   // Eight bits of d then bit a; d of FF lets the device drive, r is the ninth bit
   task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic r);
      for (int i = 8; i >= 0; i--) begin
         sda_pull <= (i > 0) ? !d[i-1] : !a;
         q4(1);
         rise();
         q4(1);
         if (i > 0) q[i-1] = sda;
         else r = sda;
         q4(1);
         scl_pull <= 1'b1;
         q4(1);
      end
   endtask : xfer
endmodule : hts_master
`default_nettype wire

// [verif/test_sensor_i2c_command_unit.sv]
// Self-checking bench of the sensor command unit with a bus master model.
// Assumes 100 MHz clock and CYCLES_PER_MS of 10, so boot takes 149 cycles.
`timescale 1ns/100ps
`default_nettype none
module test_sensor_i2c_command_unit;
   import hts_pkg::*;
   logic clk, reset_n, low_supply_in, sample_valid, r;
   logic [15:0] sample_data, s;
   logic [7:0] q;
   wire logic scl_oe, sda_oe, scl_out, sda_out, scl_pull, sda_pull, hang, conv_start, heater_on, sample_ready;
   wire hts_conv_t conv_req;
   // A pad drive of one would leave the wire high and show up as a lost bit
   wire logic scl = !(scl_pull | (scl_oe & !scl_out));
   wire logic sda = !(sda_pull | (sda_oe & !sda_out));
   int num_errors = 0;
   int check_count = 0;
   int v;
   int exp_q[$];
   hts_conv_t last_req;
   hts_unit #(.CYCLES_PER_MS(10)) DUT (.clk(clk), .reset_n(reset_n), .scl_in(scl), .scl_out(scl_out),
      .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .conv_start(conv_start),
      .conv_req(conv_req), .heater_on(heater_on), .low_supply_in(low_supply_in),
      .sample_valid(sample_valid), .sample_ready(sample_ready), .sample_data(sample_data));
   hts_master bfm (.clk(clk), .scl(scl), .sda(sda), .scl_pull(scl_pull), .sda_pull(sda_pull), .hang(hang));
   // Clock and capture of each conversion request
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) if (conv_start) last_req <= conv_req;
   always @(posedge hang) begin
      $display("Error at %0t: clock held too long", $time);
      num_errors++;
      close_out();
   end
   // Compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Bitwise checksum, most significant bit first from zero
   function automatic int crc8(input int d, input int n);
      int c = 0;
      for (int i = n - 1; i >= 0; i--) c = ((c >> 7) ^ (d >> i)) & 1 ? ((c << 1) ^ 'h31) & 'hFF : (c << 1) & 'hFF;
      return c;
   endfunction : crc8
   task automatic wr(input logic [7:0] d, input logic ack);
      bfm.xfer(d, 1'b1, q, r);
      check(!r, ack);
   endtask : wr
   task automatic rd(input int e, input logic last);
      bfm.xfer(8'hFF, last, q, r);
      check(q, e[7:0]);
   endtask : rd
   // Data bytes of n bits then the checksum, which the master refuses
   task automatic rd_all(input int d, input int n);
      for (int i = n - 8; i >= 0; i -= 8) rd(d >> i, 1'b0);
      rd(crc8(d, n), 1'b1);
   endtask : rd_all
   task automatic reg_rd(input int e);
      bfm.start();
      wr({DEV_ADDR, 1'b0}, 1'b1);
      wr(CMD_RD_REG, 1'b1);
      bfm.start();
      wr({DEV_ADDR, 1'b1}, 1'b1);
      rd_all(e, 8);
      bfm.stop();
   endtask : reg_rd
   // Front end hands one sample to the buffer
   task automatic push(input int dly);
      int k;
      repeat (dly) @(posedge clk);
      for (k = 0; k < 100 && !sample_ready; k++) @(posedge clk);
      check(sample_ready, 1'b1);
      if (!sample_ready) close_out();
      sample_data <= s;
      sample_valid <= 1'b1;
      @(posedge clk);
      sample_valid <= 1'b0;
   endtask : push
   task automatic close_out();
      $display("Checks %0d, mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : close_out
   // Main sequence
   initial begin
      reset_n = 1'b0;
      low_supply_in = 1'b0;
      sample_valid = 1'b0;
      sample_data = 16'h0000;
      s = 16'($urandom(32'h58AD));
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      repeat (170) @(posedge clk);
      reg_rd(8'h02);
      $display("Defaults done");
      // Stretched reads: the sample lands while the device holds SCL
      for (int h = 0; h < 2; h++) begin
         s = 16'($urandom);
         exp_q.push_back((s & 16'hFFFC) | (h << 1));
         bfm.start();
         wr(8'h80, 1'b1);
         wr(h ? CMD_H_HOLD : CMD_T_HOLD, 1'b1);
         check({last_req.humidity, last_req.resolution}, {h[0], 2'b00});
         fork
            push(200);
            begin
               bfm.start();
               wr(8'h81, 1'b1);
               rd_all(exp_q.pop_front(), 16);
            end
         join
         bfm.stop();
      end
      $display("Hold mode done");
      // Polled reads: refused while busy, then two bytes without checksum
      low_supply_in <= 1'b1;
      for (int h = 0; h < 2; h++) begin
         s = 16'($urandom);
         exp_q.push_back((s & 16'hFFFC) | (h << 1));
         bfm.start();
         wr(8'h80, 1'b1);
         wr(h ? CMD_H_POLL : CMD_T_POLL, 1'b1);
         // The 20 us pause scales to under one cycle on this time base
         repeat (2) @(posedge clk);
         bfm.stop();
         bfm.start();
         wr(8'h81, 1'b0);
         push(0);
         bfm.start();
         wr(8'h81, 1'b1);
         v = exp_q.pop_front();
         rd(v >> 8, 1'b0);
         rd(v, 1'b1);
         bfm.stop();
      end
      $display("Poll mode done");
      reg_rd(8'h42);
      bfm.start();
      wr(8'h80, 1'b1);
      wr(CMD_WR_REG, 1'b1);
      wr(8'h87 | (8'h42 & 8'h38), 1'b1);
      bfm.stop();
      check(heater_on, 1'b1);
      reg_rd(8'hC7);
      // Reload mode: the next measurement runs at default resolution and restores defaults, heater kept
      bfm.start();
      wr(8'h80, 1'b1);
      wr(CMD_WR_REG, 1'b1);
      wr(8'h85 | (8'hC7 & 8'h38), 1'b1);
      bfm.start();
      wr(8'h80, 1'b1);
      wr(CMD_T_POLL, 1'b1);
      bfm.stop();
      check({last_req.humidity, last_req.resolution}, 3'h0);
      reg_rd(8'h46);
      bfm.start();
      wr(8'h80, 1'b1);
      wr(8'hAA, 1'b0);
      bfm.start();
      wr(8'h82, 1'b0);
      bfm.stop();
      $display("Register done");
      bfm.start();
      wr(8'h80, 1'b1);
      wr(CMD_SOFT_RST, 1'b1);
      bfm.stop();
      repeat (170) @(posedge clk);
      reg_rd(8'h06);
      $display("Soft reset done");
      close_out();
   end
endmodule : test_sensor_i2c_command_unit
`default_nettype wire
